// >>> hdl/reset_sequencer.sv
// reset sequence manager and supply integrity logic
`timescale 1ns/10ps
`include "rst_seq_cfg.svh"
// Operation
// - three sources drive reset pin low through delay
// - fetch start address from top vector
// - active phase, 256/4096 delay, vector fetch
// - vector fetch lasts exactly two cycles
// - reset pin is input and open-drain output
// - external pin low caught without clock
// - stretch external pulse to minimum output width
// - watchdog underflow pulls pin low minimum width
// - undervoltage holds reset pin low statically
// - detector optional, threshold low/medium/high by option
// - comparator output readable as real-time flag
// - aux detector only works with detector enabled
// - select bit chooses supply or external pin
// - interrupt on every flag toggle when enabled
// - no interrupt for rise shorter than delay
// - enabling below threshold gives extra interrupt
// - wait state leaves monitor running, wakes device
// - halt freezes control/status register
// - pending interrupt cleared on service entry
// - reset cause flags, zero write clears, undervoltage clears watchdog
module reset_sequencer (
  input wire logic CLK_SYS_IN, // system clock, 100 MHz
  input wire logic SRST_IN, // synchronous reset, active high
  input wire logic RST_PIN_IN, // reset pin level, async
  output logic RST_PIN_OUT, // reset pin output value, always 0
  output logic RST_PIN_OE_OUT, // reset pin pull-down enable
  input wire logic WDG_UNDERFLOW_IN, // watchdog underflow pulse
  input wire logic LVD_UNDER_IN, // undervoltage comparator, async
  input wire logic SUPPLY_CMP_IN, // aux comparator on main supply, async
  input wire logic EXT_VOLT_CMP_IN, // aux comparator on external voltage pin, async
  input wire logic OPT_LONG_DELAY_IN, // option: 4096-cycle delay
  input wire logic OPT_LVD_EN_IN, // option: detector enabled
  input wire logic [1:0] OPT_LVD_THRESH_IN, // option: detector threshold
  input wire logic HALT_IN, // device in halt state
  input wire logic WAIT_IN, // device in wait state
  input wire logic REG_WR_IN, // control/status register write strobe
  input wire logic [7:0] REG_WDATA_IN, // control/status register write data
  input wire logic IRQ_ACK_IN, // entry into detector service routine
  output logic [7:0] REG_RDATA_OUT, // control/status register contents
  output logic CPU_RESET_OUT, // core held in reset
  output logic VEC_FETCH_OUT, // vector fetch in progress
  output logic [15:0] VEC_ADDR_OUT, // vector fetch address
  output logic IRQ_OUT, // detector interrupt request pending
  output logic WAKE_OUT, // wake from wait request
  output logic [1:0] LVD_THRESH_OUT // held detector threshold
);
  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  // two flops for every async input
  always_ff @(posedge CLK_SYS_IN) begin
    sync1_q <= {EXT_VOLT_CMP_IN, SUPPLY_CMP_IN, LVD_UNDER_IN, RST_PIN_IN};
    sync2_q <= sync1_q;
  end
  logic pin_low;
  logic lvd_raw;
  assign pin_low = ~sync2_q[0];
  assign lvd_raw = sync2_q[1];

  // ----------------------------------------------------------
  // asynchronous pin capture
  // ----------------------------------------------------------
  // latch a low pin even with the clock stopped
  // the latch is held clear for the whole sequence, so the edge that
  // our own pull-down makes on the pin never starts a second reset
  // clear wins over the pin edge when both arrive together
  logic ext_seen_q;
  logic ext_clr;
  always_ff @(negedge RST_PIN_IN or posedge ext_clr) begin
    if (ext_clr) begin
      ext_seen_q <= 1'b0;
    end else begin
      ext_seen_q <= 1'b1;
    end
  end
  logic ext_s1_q;
  logic ext_s2_q;
  always_ff @(posedge CLK_SYS_IN) begin
    ext_s1_q <= ext_seen_q;
    ext_s2_q <= ext_s1_q;
  end

  // ----------------------------------------------------------
  // option capture
  // ----------------------------------------------------------
  logic opt_long_q;
  logic opt_lvd_q;
  logic [1:0] opt_thr_q;
  // sample options while in reset, hold afterwards
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      opt_long_q <= OPT_LONG_DELAY_IN;
      opt_lvd_q <= OPT_LVD_EN_IN;
      opt_thr_q <= OPT_LVD_THRESH_IN;
    end
  end
  logic lvd_act;
  assign lvd_act = opt_lvd_q & lvd_raw;

  // ----------------------------------------------------------
  // own pull-down history
  // ----------------------------------------------------------
  // the synchronised pin lags our own pull-down by two edges, so a low
  // level counts as an external pull only once the pull-down has been
  // off for both of those edges
  logic [1:0] oe_hist_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      oe_hist_q <= 2'h3;
    end else begin
      oe_hist_q <= {oe_hist_q[0], RST_PIN_OE_OUT};
    end
  end
  // an external pull still standing after our release re-enters reset
  logic ext_hold;
  assign ext_hold = pin_low & ~(|oe_hist_q);

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  rst_seq_pkg::seq_state_t st_q;
  logic [14:0] cnt_q;
  logic wdg_start;
  logic ext_start;
  logic lvd_start;
  logic [12:0] delay_len;
  logic delay_last;
  logic fetch_last;
  // external and watchdog starts are only taken from run and fold into a running sequence; undervoltage restarts it from any state
  assign ext_start = (ext_s2_q | ext_hold) & (st_q == rst_seq_pkg::ST_RUN);
  assign wdg_start = WDG_UNDERFLOW_IN & (st_q == rst_seq_pkg::ST_RUN);
  assign lvd_start = lvd_act;
  assign delay_len = opt_long_q ? `DELAY_LONG_CYC : `DELAY_SHORT_CYC;
  // last cycle of the delay and of the fetch, shared by state and outputs
  assign delay_last = (st_q == rst_seq_pkg::ST_DELAY) && (cnt_q == 15'({2'h0, delay_len} - 15'h0001));
  assign fetch_last = (st_q == rst_seq_pkg::ST_FETCH) && (cnt_q == 15'(`FETCH_CYC - 1));
  // keep the pin latch clear while any sequence runs
  assign ext_clr = (st_q != rst_seq_pkg::ST_RUN);
  // active, delay and fetch phases
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      st_q <= rst_seq_pkg::ST_ACTIVE;
      cnt_q <= 15'h0000;
    end else if (lvd_start) begin
      st_q <= rst_seq_pkg::ST_ACTIVE;
      cnt_q <= 15'h0000;
    end else begin
      case (st_q)
        rst_seq_pkg::ST_RUN: begin
          if (ext_start | wdg_start) begin
            st_q <= rst_seq_pkg::ST_ACTIVE;
            cnt_q <= 15'h0000;
          end
        end
        rst_seq_pkg::ST_ACTIVE: begin
          // pin held for the minimum width; our own pull-down hides any
          // external pull here, so a pull that outlasts the sequence is
          // caught again from run through the pin level
          if (cnt_q >= 15'(`MIN_OUT_WIDTH_CYC - 1)) begin
            st_q <= rst_seq_pkg::ST_DELAY;
            cnt_q <= 15'h0000;
          end else begin
            cnt_q <= cnt_q + 15'h0001;
          end
        end
        rst_seq_pkg::ST_DELAY: begin
          if (delay_last) begin
            st_q <= rst_seq_pkg::ST_FETCH;
            cnt_q <= 15'h0000;
          end else begin
            cnt_q <= cnt_q + 15'h0001;
          end
        end
        rst_seq_pkg::ST_FETCH: begin
          if (fetch_last) begin
            st_q <= rst_seq_pkg::ST_RUN;
            cnt_q <= 15'h0000;
          end else begin
            cnt_q <= cnt_q + 15'h0001;
          end
        end
        default: begin
          st_q <= rst_seq_pkg::ST_ACTIVE;
          cnt_q <= 15'h0000;
        end
      endcase
    end
  end

  // pin driver and core outputs
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      RST_PIN_OUT <= 1'b0;
      RST_PIN_OE_OUT <= 1'b1;
      CPU_RESET_OUT <= 1'b1;
      VEC_FETCH_OUT <= 1'b0;
      VEC_ADDR_OUT <= `RESET_VEC_LO;
    end else begin
      RST_PIN_OUT <= 1'b0;
      RST_PIN_OE_OUT <= lvd_start | (st_q == rst_seq_pkg::ST_ACTIVE) | ext_start | wdg_start
                        | (st_q == rst_seq_pkg::ST_DELAY);
      CPU_RESET_OUT <= lvd_start | (st_q != rst_seq_pkg::ST_RUN) | ext_start | wdg_start;
      // fetch flag stands for the two fetch cycles only, not the delay
      VEC_FETCH_OUT <= ~lvd_start & (delay_last | ((st_q == rst_seq_pkg::ST_FETCH) & ~fetch_last));
      VEC_ADDR_OUT <= (st_q == rst_seq_pkg::ST_FETCH) ? `RESET_VEC_HI : `RESET_VEC_LO;
    end
  end

  // ----------------------------------------------------------
  // supply integrity control/status
  // ----------------------------------------------------------
  logic sel_q;
  logic ie_q;
  logic flag_q;
  logic lvrf_q;
  logic wdrf_q;
  logic pend_q;
  logic cmp_now;
  logic in_reset;
  // the comparator is only seen through the synchroniser, so the flag
  // trails the analogue level by three clocks; software bits restart at
  // zero after every sequence, the cause flags do not
  assign in_reset = (st_q != rst_seq_pkg::ST_RUN);
  assign cmp_now = opt_lvd_q & (sel_q ? sync2_q[3] : sync2_q[2]);
  // software bits and live flag, frozen in halt
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sel_q <= 1'b0;
      ie_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (in_reset) begin
      sel_q <= 1'b0;
      ie_q <= 1'b0;
      flag_q <= cmp_now; // no edge seen across reset
    end else if (!HALT_IN) begin
      flag_q <= cmp_now;
      if (REG_WR_IN) begin
        sel_q <= REG_WDATA_IN[`STAT_SEL_BIT];
        ie_q <= REG_WDATA_IN[`STAT_IE_BIT];
      end
    end
  end
  // pending request: toggle or enable while flagged sets, service entry clears
  logic ie_rise;
  assign ie_rise = REG_WR_IN & REG_WDATA_IN[`STAT_IE_BIT] & ~ie_q & cmp_now;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || in_reset) begin
      pend_q <= 1'b0;
    end else if (!HALT_IN) begin
      if ((ie_q && (cmp_now != flag_q)) || ie_rise) begin
        pend_q <= 1'b1;
      end else if (IRQ_ACK_IN) begin
        pend_q <= 1'b0;
      end
    end
  end
  // reset cause flags survive the device reset
  // an undervoltage both sets its own flag and clears the watchdog flag,
  // so a stale watchdog cause never outlives a supply failure
  always_ff @(posedge CLK_SYS_IN) begin
    if (lvd_start) begin
      lvrf_q <= 1'b1;
      wdrf_q <= 1'b0;
    end else if (!HALT_IN) begin
      if (wdg_start) begin
        wdrf_q <= 1'b1;
      end else if (REG_WR_IN && !REG_WDATA_IN[`STAT_WDRF_BIT]) begin
        wdrf_q <= 1'b0;
      end
      if (REG_WR_IN && !REG_WDATA_IN[`STAT_LVRF_BIT]) begin
        lvrf_q <= 1'b0;
      end
    end
  end
  // registered outputs
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT <= 8'h00;
      IRQ_OUT <= 1'b0;
      WAKE_OUT <= 1'b0;
      LVD_THRESH_OUT <= OPT_LVD_THRESH_IN; // no step when reset is released
    end else begin
      REG_RDATA_OUT <= {sel_q, ie_q, flag_q, lvrf_q, 3'h0, wdrf_q};
      IRQ_OUT <= pend_q;
      WAKE_OUT <= pend_q & WAIT_IN;
      LVD_THRESH_OUT <= opt_thr_q;
    end
  end
endmodule

// >>> hdl/rst_seq_cfg.svh
// constants for the reset sequencer and supply monitor
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH
`define CLK_PERIOD_NS 10
`define DELAY_SHORT_CYC 13'h0100
`define DELAY_LONG_CYC 13'h1000
`define FETCH_CYC 2'h2
`define RESET_VEC_LO 16'hFFFE
`define RESET_VEC_HI 16'hFFFF
`define MIN_OUT_WIDTH_NS 20000
`define MIN_OUT_WIDTH_CYC (`MIN_OUT_WIDTH_NS / `CLK_PERIOD_NS)
`define STAT_SEL_BIT 7
`define STAT_IE_BIT 6
`define STAT_FLAG_BIT 5
`define STAT_LVRF_BIT 4
`define STAT_WDRF_BIT 0
`endif

// >>> hdl/rst_seq_pkg.sv
// types for the reset sequencer and supply monitor
package rst_seq_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_DELAY = 4'h4,
    ST_FETCH = 4'h8
  } seq_state_t;
  typedef enum logic [1:0] {
    THR_LOW = 2'h0,
    THR_MED = 2'h1,
    THR_HIGH = 2'h2
  } lvd_thresh_t;
endpackage

// >>> bench/ext_reset_circuit.sv
// board-side model of the reset line: external pull-down and weak pull-up
`timescale 1ns/10ps
module ext_reset_circuit (
  input wire logic pull_in, // external circuit pulls the line low
  input wire logic oe_in, // device pull-down enable
  input wire logic drv_in, // device output value
  output logic pin_out // resolved line level
);
  // open-drain wire: low if any party pulls, else the weak pull-up wins
  assign pin_out = (pull_in || (oe_in && !drv_in)) ? 1'b0 : 1'b1;
endmodule

// >>> bench/reset_sequencer_props.sv
// assertions on the reset sequencer ports
`timescale 1ns/10ps
module reset_sequencer_props (
  input wire logic CLK_SYS_IN, // clock
  input wire logic SRST_IN, // reset
  input wire logic WDG_UNDERFLOW_IN, // watchdog pulse
  input wire logic LVD_UNDER_IN, // undervoltage
  input wire logic HALT_IN, // halt state
  input wire logic WAIT_IN, // wait state
  input wire logic OPT_LVD_EN_IN, // detector option
  input wire logic RST_PIN_OE_OUT, // pin pull-down
  input wire logic CPU_RESET_OUT, // core reset
  input wire logic VEC_FETCH_OUT, // vector fetch
  input wire logic [15:0] VEC_ADDR_OUT, // fetch address
  input wire logic IRQ_OUT, // interrupt
  input wire logic WAKE_OUT, // wake request
  input wire logic [7:0] REG_RDATA_OUT, // register contents
  input wire logic [1:0] LVD_THRESH_OUT // held threshold
);
  localparam int MIN_LOW = 2200;
  int low_q;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  // counts how long the pin has been pulled low
  always_ff @(posedge CLK_SYS_IN) begin
    low_q <= (SRST_IN || !RST_PIN_OE_OUT) ? 0 : low_q + 1;
  end
  sequence s_fetch;
    VEC_ADDR_OUT == 16'hFFFE ##1 VEC_FETCH_OUT && VEC_ADDR_OUT == 16'hFFFF ##1 !VEC_FETCH_OUT;
  endsequence
  a_fetch_two_cyc: assert property ($rose(VEC_FETCH_OUT) |-> s_fetch)
    else $error("vector fetch wrong");
  a_pin_before_fetch: assert property ($rose(VEC_FETCH_OUT) |-> $past(RST_PIN_OE_OUT))
    else $error("pin released before fetch");
  a_pin_min_width: assert property ($fell(RST_PIN_OE_OUT) |-> low_q >= MIN_LOW)
    else $error("pin low too short");
  a_wdg_starts_rst: assert property (WDG_UNDERFLOW_IN && !CPU_RESET_OUT |=> RST_PIN_OE_OUT && CPU_RESET_OUT)
    else $error("watchdog reset missing");
  a_lvd_holds_pin: assert property ((OPT_LVD_EN_IN && LVD_UNDER_IN) [*4] |-> RST_PIN_OE_OUT && CPU_RESET_OUT)
    else $error("undervoltage not holding pin");
  a_wake_cause: assert property (WAKE_OUT |-> IRQ_OUT && $past(WAIT_IN))
    else $error("wake without cause");
  a_halt_frozen: assert property (HALT_IN && $past(HALT_IN) && $past(HALT_IN, 2) && !CPU_RESET_OUT
    |-> $stable(REG_RDATA_OUT))
    else $error("register changed in halt");
  a_aux_idle_off: assert property (!OPT_LVD_EN_IN && !CPU_RESET_OUT |-> !IRQ_OUT && !REG_RDATA_OUT[5])
    else $error("aux detector active while off");
  a_thresh_held: assert property (!$past(SRST_IN) |-> $stable(LVD_THRESH_OUT))
    else $error("threshold changed in run");
endmodule
bind reset_sequencer reset_sequencer_props reset_sequencer_props_i (.CLK_SYS_IN, .SRST_IN, .WDG_UNDERFLOW_IN,
  .LVD_UNDER_IN, .HALT_IN, .WAIT_IN, .OPT_LVD_EN_IN, .RST_PIN_OE_OUT, .CPU_RESET_OUT, .VEC_FETCH_OUT,
  .VEC_ADDR_OUT, .IRQ_OUT, .WAKE_OUT, .REG_RDATA_OUT, .LVD_THRESH_OUT);

// >>> bench/reset_sequencer_tb_top.sv
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module reset_sequencer_tb_top;
  logic clk = 1'b0, srst = 1'b1, wdg = 1'b0, low_voltage_detector = 1'b0, sup = 1'b0, external_voltage_pin = 1'b0, olong = 1'b0, olvd = 1'b1;
  logic halt = 1'b0, wt = 1'b0, wr = 1'b0, ack = 1'b0, pull = 1'b0;
  logic pin, pin_o, oe, crst, vf, irq, wake;
  logic [1:0] thr = 2'h2, tho;
  logic [7:0] wd = 8'h00, rd;
  logic [15:0] va;
  int err_count = 0, total_checks = 0, n;
  always #5 clk = ~clk;
  reset_sequencer reset_sequencer_i (.CLK_SYS_IN(clk), .SRST_IN(srst), .RST_PIN_IN(pin), .RST_PIN_OUT(pin_o),
    .RST_PIN_OE_OUT(oe), .WDG_UNDERFLOW_IN(wdg), .LVD_UNDER_IN(low_voltage_detector), .SUPPLY_CMP_IN(sup), .EXT_VOLT_CMP_IN(external_voltage_pin),
    .OPT_LONG_DELAY_IN(olong), .OPT_LVD_EN_IN(olvd), .OPT_LVD_THRESH_IN(thr), .HALT_IN(halt), .WAIT_IN(wt),
    .REG_WR_IN(wr), .REG_WDATA_IN(wd), .IRQ_ACK_IN(ack), .REG_RDATA_OUT(rd), .CPU_RESET_OUT(crst),
    .VEC_FETCH_OUT(vf), .VEC_ADDR_OUT(va), .IRQ_OUT(irq), .WAKE_OUT(wake), .LVD_THRESH_OUT(tho));
  ext_reset_circuit ext_reset_circuit_i (.pull_in(pull), .oe_in(oe), .drv_in(pin_o), .pin_out(pin));
  // compare, access and wait helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task wr_reg(input logic [7:0] d);
    wr <= 1'b1;
    wd <= d;
    cyc(1);
    wr <= 1'b0;
    cyc(3);
  endtask
  task ackp;
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(2);
  endtask
  task wait_seq(output int c);
    c = 0;
    while (crst !== 1'b0 && c < 12000) begin
      @(posedge clk);
      c++;
    end
    cyc(2);
  endtask
  task reset_dut;
    srst <= 1'b1;
    cyc(12);
    srst <= 1'b0;
    cyc(2);
    wait_seq(n);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cuts a hang short
  initial begin
    cyc(45000);
    err_count++;
    final_report;
  end
  // main sequence
  initial begin
    reset_dut;
    chk(n < 2400, 1);
    chk(tho, 2'h2);
    wr_reg(8'h00);
    chk(rd, 8'h00);
    wdg <= 1'b1;
    cyc(1);
    wdg <= 1'b0;
    cyc(2);
    chk(pin, 0);
    wait_seq(n);
    chk(n >= 2258 && n < 2400, 1);
    chk(rd, 8'h01);
    low_voltage_detector <= 1'b1;
    cyc(50);
    chk(pin, 0);
    low_voltage_detector <= 1'b0;
    cyc(3);
    wait_seq(n);
    chk(rd, 8'h10);
    olong <= 1'b1;
    reset_dut;
    chk(n >= 6098 && n < 6300, 1);
    halt <= 1'b1;
    pull <= 1'b1;
    cyc(5);
    pull <= 1'b0;
    chk(crst, 1);
    halt <= 1'b0;
    cyc(1900);
    chk(pin, 0);
    wait_seq(n);
    wr_reg(8'h00);
    wr_reg(8'h40);
    sup <= 1'b1;
    cyc(5);
    chk(irq, 1);
    chk(rd, 8'h60);
    ackp;
    chk(irq, 0);
    wt <= 1'b1;
    sup <= 1'b0;
    cyc(5);
    chk(wake, 1);
    ackp;
    wt <= 1'b0;
    sup <= 1'b1;
    wr_reg(8'hC0);
    cyc(3);
    ackp;
    sup <= 1'b0;
    cyc(5);
    chk(irq, 0);
    external_voltage_pin <= 1'b1;
    cyc(5);
    chk(irq, 1);
    wr_reg(8'h80);
    ackp;
    wr_reg(8'hC0);
    chk(irq, 1);
    wr_reg(8'h80);
    ackp;
    external_voltage_pin <= 1'b0;
    cyc(5);
    chk(irq, 0);
    halt <= 1'b1;
    cyc(2);
    external_voltage_pin <= 1'b1;
    cyc(5);
    chk(rd, 8'h80);
    halt <= 1'b0;
    cyc(5);
    chk(rd, 8'hA0);
    olvd <= 1'b0;
    thr <= 2'h1;
    reset_dut;
    chk(tho, 2'h1);
    wr_reg(8'h40);
    sup <= 1'b1;
    cyc(5);
    chk(irq, 0);
    chk(rd, 8'h40);
    final_report;
  end
endmodule
